// File: verilog/port_storm_rate_policer.sv
// Summary of operation
// [R01] forward unregistered multicast in forward mode
// [R02] drop unregistered multicast in filter mode
// [R03] drop threshold is N times 64 kbit/s
// [R04] storm control disabled after reset
// [R05] storm classes: any broadcast/multicast/unknown mix
// [R06] drop action discards excess storm frames
// [R07] shutdown blocks all but BPDUs
// [R08] countdown expiry enters rest, five-minute recovery
// [R09] countdown 0 or 5-30, 0 never shuts
// [R10] countdown ignored under drop action
// [R11] sample interval 5-30 s, default 5
// [R12] shutdown detection uses sampled packet counts
// [R13] shutdown threshold 0 to 255000
// [R14] no storm control on aggregated ports
// [R15] rest mode reports discarding, BPDUs to cpu
// [R16] rest mode reports link down
// [R17] bandwidth ceiling on rx, tx or both
// [R18] no-limit setting removes bandwidth ceiling
// [R19] bandwidth rate 63 to 1024000 kbit/s
// [R20] gigabit tx rate rounded down to 1850
// [R21] strict: top queue first, rest weighted
// [R22] wrr shares slots by queue weight
// [R23] storm counters cleared each sampling interval
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// token bucket in bits, refilled once per millisecond with rate kbit/s
module token_bucket
  import storm_policer_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        refill,
  input  wire logic        take,
  input  wire logic [19:0] rate,
  input  wire logic [16:0] cost,
  output logic             ok
);
  logic [20:0] level_reg;
  logic [20:0] base;
  logic [21:0] sum;
  logic [21:0] cap;

  // one frame of burst above the rate so slow rates still pass frames
  always_comb begin
    base = (take && ok) ? level_reg - {4'h0, cost} : level_reg;
    sum  = {1'b0, base} + {2'h0, rate};
    cap  = {2'h0, rate} + {1'b0, MAX_FRAME_BITS};
  end

  assign ok = level_reg >= {4'h0, cost};

  // refill and spend may share a cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      level_reg <= 21'h00000;
    end else if (refill) begin
      level_reg <= (sum > cap) ? cap[20:0] : sum[20:0];
    end else begin
      level_reg <= base;
    end
  end
endmodule

module port_storm_rate_policer
  import storm_policer_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES,
  parameter int NUM_QUEUES  = 8
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic [31:0]                        reg_rdata,
  // receive path
  input  wire logic                          rx_valid,
  input  wire rx_frame_type                  rx_frame,
  output rx_verdict_type                     rx_verdict,
  // transmit path
  input  wire logic                          tx_valid,
  input  wire logic [13:0]                   tx_len,
  output logic                               tx_done,
  output logic                               tx_pass,
  // egress scheduler
  input  wire logic [NUM_QUEUES-1:0]         queue_req,
  input  wire logic                          sched_ready,
  output logic                               grant_valid,
  output logic [$clog2(NUM_QUEUES)-1:0]      grant_queue,
  // port status
  output port_status_type                    port_status
);
  localparam int QW = $clog2(NUM_QUEUES);
  localparam logic [QW-1:0] TOP_Q = QW'(NUM_QUEUES - 1);

  if (NUM_QUEUES < 2 || NUM_QUEUES > 8 || MS_CYCLES_P < 1) begin : g_bad_param
    $error("port_storm_rate_policer: unsupported parameter value");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [12:0]     ctrl_reg;
  logic [13:0]     drop_n_reg;
  logic [4:0]      countdown_reg;
  logic [4:0]      interval_reg;
  logic [17:0]     shut_th_reg;
  logic [19:0]     bw_rate_reg;
  logic [19:0]     sample_reg;
  logic [5:0]      weight_reg [NUM_QUEUES];
  logic            recover_wr;
  storm_state_type state_reg;
  logic            drop_storm_reg;
  logic [31:0]     wd;
  logic [QW-1:0]   widx;
  logic            w_hit;

  assign wd    = reg_wdata;
  assign widx  = reg_addr[QW+1:2];
  assign w_hit = reg_addr[7:QW+2] == OFF_WEIGHT[7:QW+2];
  assign recover_wr = reg_write && reg_addr == OFF_CTRL && wd[C_RECOVER];

  // writes clamp into the legal ranges so the logic never sees a bad value
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_reg      <= 13'h000; // see [R04]
      drop_n_reg    <= DROP_N_MIN;
      countdown_reg <= 5'h00;
      interval_reg  <= IV_DEF; // see [R11]
      shut_th_reg   <= 18'h00000;
      bw_rate_reg   <= RATE_MAX;
    end else if (reg_write) begin
      unique case (reg_addr)
        OFF_CTRL: ctrl_reg <= {1'b0, wd[11:0]};
        OFF_DROP_N: drop_n_reg <= (wd[13:0] < DROP_N_MIN || wd[31:14] != 18'h00000) ?
            ((wd[31:14] != 18'h00000) ? DROP_N_MAX : DROP_N_MIN) :
            (wd[13:0] > DROP_N_MAX) ? DROP_N_MAX : wd[13:0]; // see [R03]
        OFF_COUNTDOWN: countdown_reg <= (wd[31:0] == 32'h0) ? 5'h00 :
            (wd[31:0] < {27'h0, CD_MIN}) ? CD_MIN :
            (wd[31:0] > {27'h0, CD_MAX}) ? CD_MAX : wd[4:0]; // see [R09]
        OFF_INTERVAL: interval_reg <= (wd[31:0] < {27'h0, IV_MIN}) ? IV_MIN :
            (wd[31:0] > {27'h0, IV_MAX}) ? IV_MAX : wd[4:0]; // see [R11]
        OFF_SHUT_TH: shut_th_reg <= (wd[31:0] > {14'h0, SHUT_MAX}) ?
            SHUT_MAX : wd[17:0]; // see [R13]
        OFF_BW_RATE: bw_rate_reg <= (wd[31:0] < {12'h0, RATE_MIN}) ? RATE_MIN :
            (wd[31:0] > {12'h0, RATE_MAX}) ? RATE_MAX : wd[19:0]; // see [R19]
        default: ;
      endcase
    end
  end

  // queue weights, one word each above the weight base
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int q = 0; q < NUM_QUEUES; q++) begin
        weight_reg[q] <= WEIGHT_MIN;
      end
    end else if (reg_write && w_hit && int'(widx) < NUM_QUEUES) begin
      weight_reg[widx] <= (wd[31:0] < {26'h0, WEIGHT_MIN}) ? WEIGHT_MIN :
          (wd[31:0] > {26'h0, WEIGHT_MAX}) ? WEIGHT_MAX : wd[5:0];
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (reset || !reg_read) begin
      reg_rdata <= 32'h00000000;
    end else if (w_hit && int'(widx) < NUM_QUEUES) begin
      reg_rdata <= {26'h0, weight_reg[widx]};
    end else begin
      unique case (reg_addr)
        OFF_CTRL:      reg_rdata <= {19'h0, ctrl_reg};
        OFF_DROP_N:    reg_rdata <= {18'h0, drop_n_reg};
        OFF_COUNTDOWN: reg_rdata <= {27'h0, countdown_reg};
        OFF_INTERVAL:  reg_rdata <= {27'h0, interval_reg};
        OFF_SHUT_TH:   reg_rdata <= {14'h0, shut_th_reg};
        OFF_BW_RATE:   reg_rdata <= {12'h0, bw_rate_reg};
        OFF_STATUS:    reg_rdata <= {27'h0, state_reg, port_status};
        OFF_SAMPLE:    reg_rdata <= {12'h0, sample_reg};
        default:       reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // time base: millisecond, second, minute and sample ticks
  // ****************************************************************
  logic [$clog2(MS_CYCLES_P+1)-1:0] ms_cnt_reg;
  logic [9:0] msec_reg;
  logic [5:0] sec_reg;
  logic [4:0] iv_cnt_reg;
  logic       ms_tick;
  logic       sec_tick;
  logic       min_tick;
  logic       sample_tick;

  assign ms_tick     = ms_cnt_reg == ($bits(ms_cnt_reg))'(MS_CYCLES_P - 1);
  assign sec_tick    = ms_tick && msec_reg == MS_PER_SEC - 10'h001;
  assign min_tick    = sec_tick && sec_reg == SEC_PER_MIN - 6'h01;
  assign sample_tick = sec_tick && iv_cnt_reg >= interval_reg - 5'h01;

  // cascaded dividers, every slower rate is a one-cycle enable
  always_ff @(posedge clock) begin
    if (reset) begin
      ms_cnt_reg <= '0;
      msec_reg   <= 10'h000;
      sec_reg    <= 6'h00;
      iv_cnt_reg <= 5'h00;
    end else begin
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
      if (ms_tick) begin
        msec_reg <= sec_tick ? 10'h000 : msec_reg + 10'h001;
      end
      if (sec_tick) begin
        sec_reg    <= min_tick ? 6'h00 : sec_reg + 6'h01;
        iv_cnt_reg <= sample_tick ? 5'h00 : iv_cnt_reg + 5'h01; // see [R11]
      end
    end
  end

  // ****************************************************************
  // storm control
  // ****************************************************************
  logic        enabled;
  logic        shut_mode;
  logic        match;
  logic        over;
  logic [19:0] pkt_cnt_reg;
  logic [4:0]  min_cnt_reg;

  // aggregated ports never see storm control
  assign enabled   = ctrl_reg[C_STORM_EN] && !ctrl_reg[C_LAG]; // see [R04] see [R14]
  assign shut_mode = enabled && ctrl_reg[C_ACTION];
  assign match     = rx_valid && |(ctrl_reg[C_TYPE +: 3] &
      {rx_frame.unk_ucast, rx_frame.mcast, rx_frame.bcast}); // see [R05]
  assign over      = pkt_cnt_reg > {2'h0, shut_th_reg}; // see [R12]

  // counter restarts each interval; a frame in the sample cycle opens the next
  always_ff @(posedge clock) begin
    if (reset) begin
      pkt_cnt_reg <= 20'h00000;
      sample_reg  <= 20'h00000;
    end else if (sample_tick) begin
      sample_reg  <= pkt_cnt_reg; // see [R11]
      pkt_cnt_reg <= match ? 20'h00001 : 20'h00000; // see [R23]
    end else if (match && pkt_cnt_reg != 20'hfffff) begin
      pkt_cnt_reg <= pkt_cnt_reg + 20'h00001;
    end
  end

  // shutdown sequence; drop action keeps the port in normal state
  always_ff @(posedge clock) begin
    if (reset || !shut_mode) begin
      state_reg   <= ST_NORMAL; // see [R10]
      min_cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        ST_NORMAL: begin
          min_cnt_reg <= 5'h00;
          if (sample_tick && over) begin
            state_reg <= ST_BLOCKED; // see [R07]
          end
        end
        ST_BLOCKED: begin
          if (min_tick && min_cnt_reg != CD_MAX) begin
            min_cnt_reg <= min_cnt_reg + 5'h01;
          end
          if (sample_tick && !over) begin
            state_reg <= ST_NORMAL;
          end else if (sample_tick && countdown_reg != 5'h00 &&
                       min_cnt_reg >= countdown_reg) begin
            state_reg   <= ST_REST; // see [R08] see [R09]
            min_cnt_reg <= 5'h00;
          end
        end
        ST_REST: begin
          if (recover_wr) begin
            state_reg <= ST_NORMAL; // see [R16]
          end else if (min_tick) begin
            min_cnt_reg <= min_cnt_reg + 5'h01;
            if (min_cnt_reg == REST_MIN - 5'h01) begin
              state_reg <= ST_RECOVER; // see [R08]
            end
          end
        end
        ST_RECOVER: begin
          state_reg   <= ST_NORMAL;
          min_cnt_reg <= 5'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // receive and transmit policing
  // ****************************************************************
  logic        storm_ok;
  logic        rx_bw_ok;
  logic        tx_bw_ok;
  logic        mc_ok;
  logic        gate_ok;
  logic        storm_drop;
  logic        rx_bw_on;
  logic        tx_bw_on;
  logic        rx_ok;
  logic [19:0] drop_rate;
  logic [19:0] tx_rate;

  assign drop_rate  = 20'(drop_n_reg * DROP_STEP); // see [R03]
  assign tx_rate    = ctrl_reg[C_GIG] ? 20'((bw_rate_reg / GIG_STEP) * GIG_STEP) :
                      bw_rate_reg; // see [R20]
  assign mc_ok      = !(rx_frame.mcast && !rx_frame.registered &&
                        ctrl_reg[C_MC_FILTER]); // see [R01] see [R02]
  assign gate_ok    = rx_frame.bpdu || state_reg == ST_NORMAL ||
                      state_reg == ST_RECOVER; // see [R07]
  assign storm_drop = enabled && !ctrl_reg[C_ACTION] && match && !storm_ok; // see [R06]
  assign rx_bw_on   = !ctrl_reg[C_NO_LIMIT] && ctrl_reg[C_DIR]; // see [R17] see [R18]
  assign tx_bw_on   = !ctrl_reg[C_NO_LIMIT] && ctrl_reg[C_DIR+1]; // see [R17] see [R18]
  assign rx_ok      = rx_valid && mc_ok && gate_ok && !storm_drop &&
                      state_reg != ST_REST && (!rx_bw_on || rx_bw_ok);

  token_bucket u_storm_bucket (
    .clock  (clock),
    .reset  (reset),
    .refill (ms_tick),
    .take   (rx_ok && match),
    .rate   (drop_rate),
    .cost   ({rx_frame.len, 3'h0}),
    .ok     (storm_ok)
  );

  token_bucket u_rx_bucket (
    .clock  (clock),
    .reset  (reset),
    .refill (ms_tick),
    .take   (rx_ok && rx_bw_on),
    .rate   (bw_rate_reg),
    .cost   ({rx_frame.len, 3'h0}),
    .ok     (rx_bw_ok)
  );

  token_bucket u_tx_bucket (
    .clock  (clock),
    .reset  (reset),
    .refill (ms_tick),
    .take   (tx_valid && tx_bw_on),
    .rate   (tx_rate),
    .cost   ({tx_len, 3'h0}),
    .ok     (tx_bw_ok)
  );

  // verdicts one cycle after the request; BPDUs always copied to the cpu
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_verdict <= '0;
      tx_done    <= 1'b0;
      tx_pass    <= 1'b0;
    end else begin
      rx_verdict.done   <= rx_valid;
      rx_verdict.pass   <= rx_ok;
      rx_verdict.to_cpu <= rx_valid && rx_frame.bpdu; // see [R15]
      tx_done           <= tx_valid;
      tx_pass           <= tx_valid && (!tx_bw_on || tx_bw_ok);
    end
  end

  // drop-action storm flag; a new drop wins over the interval clear
  always_ff @(posedge clock) begin
    if (reset || !enabled) begin
      drop_storm_reg <= 1'b0;
    end else if (storm_drop) begin
      drop_storm_reg <= 1'b1;
    end else if (sample_tick) begin
      drop_storm_reg <= 1'b0;
    end
  end

  assign port_status.link_up     = state_reg != ST_REST; // see [R16]
  assign port_status.stp_discard = state_reg == ST_REST; // see [R15]
  assign port_status.storm       = drop_storm_reg || state_reg == ST_BLOCKED ||
                                   state_reg == ST_REST;

  // ****************************************************************
  // egress scheduler
  // ****************************************************************
  logic [QW-1:0] ptr_reg;
  logic [QW-1:0] ptr_next;
  logic [5:0]    credit_reg;
  logic          strict;

  assign strict   = ctrl_reg[C_STRICT];
  assign ptr_next = (ptr_reg == TOP_Q || (strict && ptr_reg == TOP_Q - 1'b1)) ?
                    '0 : ptr_reg + 1'b1;

  // one decision a cycle; a queue keeps the slot until its credit runs out or it stops requesting
  always_ff @(posedge clock) begin
    if (reset) begin
      ptr_reg     <= '0;
      credit_reg  <= WEIGHT_MIN;
      grant_valid <= 1'b0;
      grant_queue <= '0;
    end else begin
      grant_valid <= 1'b0;
      if (sched_ready) begin
        if (strict && queue_req[TOP_Q]) begin
          grant_valid <= 1'b1; // see [R21]
          grant_queue <= TOP_Q;
        end else if (queue_req[ptr_reg] && credit_reg != 6'h00 &&
                     !(strict && ptr_reg == TOP_Q)) begin
          grant_valid <= 1'b1; // see [R22]
          grant_queue <= ptr_reg;
          credit_reg  <= credit_reg - 6'h01;
        end else begin
          ptr_reg    <= ptr_next;
          credit_reg <= weight_reg[ptr_next]; // see [R22]
        end
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_filter_unreg: assert property ( // see [R02]
    rx_valid && rx_frame.mcast && !rx_frame.registered && ctrl_reg[C_MC_FILTER]
    |=> rx_verdict.done && !rx_verdict.pass)
    else $error("unregistered multicast passed in filter mode");
  a_forward_unreg: assert property ( // see [R01]
    rx_valid && rx_frame.mcast && !rx_frame.registered && !ctrl_reg[C_MC_FILTER] &&
    !enabled && ctrl_reg[C_NO_LIMIT] |=> rx_verdict.pass)
    else $error("unregistered multicast dropped in forward mode");
  a_blocked_bpdu: assert property ( // see [R07]
    rx_valid && !rx_frame.bpdu && state_reg inside {ST_BLOCKED, ST_REST}
    |=> !rx_verdict.pass)
    else $error("non-BPDU frame passed while blocked");
  a_reset_defaults: assert property (disable iff (1'b0) // see [R04]
    reset |=> !ctrl_reg[C_STORM_EN] && interval_reg == IV_DEF && state_reg == ST_NORMAL)
    else $error("storm control not idle after reset");
  a_never_shut: assert property ( // see [R09]
    state_reg == ST_BLOCKED && countdown_reg == 5'h00 && shut_mode |=> state_reg != ST_REST)
    else $error("port entered rest with countdown zero");
  a_drop_no_fsm: assert property ( // see [R10]
    !shut_mode |=> state_reg == ST_NORMAL [*2])
    else $error("shutdown state left normal outside shutdown action");
  a_rest_report: assert property ( // see [R16]
    $rose(state_reg == ST_REST) |-> !port_status.link_up && port_status.stp_discard &&
    $past(state_reg) == ST_BLOCKED)
    else $error("rest entered without link down report");
  a_count_clear: assert property ( // see [R23]
    sample_tick |=> pkt_cnt_reg <= 20'h00001 && sample_reg == $past(pkt_cnt_reg))
    else $error("storm counter not cleared at sample");
  a_strict_top: assert property ( // see [R21]
    sched_ready && strict && queue_req[TOP_Q] |=> grant_valid && grant_queue == TOP_Q)
    else $error("strict mode did not serve the top queue");
  a_storm_drop: assert property ( // see [R06]
    rx_valid && storm_drop |=> rx_verdict.done && !rx_verdict.pass && port_status.storm)
    else $error("excess storm frame not discarded");
  a_drop_range: assert property ( // see [R03]
    drop_n_reg >= DROP_N_MIN && drop_n_reg <= DROP_N_MAX)
    else $error("drop multiplier out of range");

  c_rest_mode: cover property (state_reg == ST_BLOCKED ##1 state_reg == ST_REST);
  c_recover:   cover property (state_reg == ST_RECOVER ##1 state_reg == ST_NORMAL);
  c_storm_drp: cover property (rx_valid && storm_drop);
  c_wrr_low:   cover property (grant_valid && grant_queue == '0 ##1 grant_valid);
endmodule

`default_nettype wire

// File: inc/storm_policer_pkg.sv
package storm_policer_pkg;
  // register map, byte addresses
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_DROP_N    = 8'h04;
  localparam logic [7:0] OFF_COUNTDOWN = 8'h08;
  localparam logic [7:0] OFF_INTERVAL  = 8'h0c;
  localparam logic [7:0] OFF_SHUT_TH   = 8'h10;
  localparam logic [7:0] OFF_BW_RATE   = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_SAMPLE    = 8'h1c;
  localparam logic [7:0] OFF_WEIGHT    = 8'h20;
  // control register fields
  localparam int C_STORM_EN  = 0;
  localparam int C_ACTION    = 1;
  localparam int C_TYPE      = 2;
  localparam int C_MC_FILTER = 5;
  localparam int C_LAG       = 6;
  localparam int C_NO_LIMIT  = 7;
  localparam int C_DIR       = 8;
  localparam int C_GIG       = 10;
  localparam int C_STRICT    = 11;
  localparam int C_RECOVER   = 12;
  // legal ranges and reset values
  localparam logic [13:0] DROP_N_MIN = 14'h0001;
  localparam logic [13:0] DROP_N_MAX = 14'h3e80;
  localparam logic [19:0] DROP_STEP  = 20'h00040;
  localparam logic [4:0]  CD_MIN     = 5'h05;
  localparam logic [4:0]  CD_MAX     = 5'h1e;
  localparam logic [4:0]  IV_MIN     = 5'h05;
  localparam logic [4:0]  IV_MAX     = 5'h1e;
  localparam logic [4:0]  IV_DEF     = 5'h05;
  localparam logic [17:0] SHUT_MAX   = 18'h3e418;
  localparam logic [19:0] RATE_MIN   = 20'h0003f;
  localparam logic [19:0] RATE_MAX   = 20'hfa000;
  localparam logic [19:0] GIG_STEP   = 20'h0073a;
  localparam logic [5:0]  WEIGHT_MIN = 6'h01;
  localparam logic [5:0]  WEIGHT_MAX = 6'h37;
  localparam logic [20:0] MAX_FRAME_BITS = 21'h02f70;
  // time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] MS_PER_SEC  = 10'h3e8;
  localparam logic [5:0] SEC_PER_MIN = 6'h3c;
  localparam logic [4:0] REST_MIN    = 5'h05;
  typedef enum logic [1:0] {ST_NORMAL, ST_BLOCKED, ST_REST, ST_RECOVER} storm_state_type;
  typedef struct packed {
    logic        bcast;
    logic        mcast;
    logic        unk_ucast;
    logic        registered;
    logic        bpdu;
    logic [13:0] len;
  } rx_frame_type;
  typedef struct packed {
    logic done;
    logic pass;
    logic to_cpu;
  } rx_verdict_type;
  typedef struct packed {
    logic link_up;
    logic stp_discard;
    logic storm;
  } port_status_type;
endpackage

// File: bench/port_path_model.sv
`timescale 1ns/10ps
`default_nettype none

// receive path source: one frame a pulse, line scrambled once released
module port_path_model
  import storm_policer_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // bench side
  input  wire logic         send,
  input  wire rx_frame_type frame_in,
  // device side
  output logic              rx_valid,
  output rx_frame_type      rx_frame
);
  // a stale frame would hide a design that samples late, so invert it
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_frame <= '0;
    end else if (send) begin
      rx_valid <= 1'b1;
      rx_frame <= frame_in;
    end else begin
      rx_valid <= 1'b0;
      rx_frame <= ~rx_frame;
    end
  end
endmodule

`default_nettype wire

// File: bench/port_storm_rate_policer_test.sv
`timescale 1ns/10ps
`default_nettype none

module port_storm_rate_policer_test;
  import storm_policer_pkg::*;
  logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic send = 1'b0, tx_valid = 1'b0, sched_ready = 1'b0, rx_valid;
  logic [7:0] reg_addr = 8'h00, queue_req = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'hb256;
  logic [13:0] tx_len = 14'h0040;
  rx_frame_type frame_in = '0, rx_frame;
  rx_verdict_type rx_verdict;
  port_status_type port_status;
  logic tx_done, tx_pass, grant_valid;
  logic [2:0] grant_queue;
  int err_total = 0, compares = 0;

  always #2 clock = ~clock;

  port_path_model path (.clock(clock), .reset(reset), .send(send), .frame_in(frame_in),
    .rx_valid(rx_valid), .rx_frame(rx_frame));
  port_storm_rate_policer #(.MS_CYCLES_P(4), .NUM_QUEUES(8)) uut (.clock(clock),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .rx_verdict(rx_verdict), .tx_valid(tx_valid), .tx_len(tx_len), .tx_done(tx_done),
    .tx_pass(tx_pass), .queue_req(queue_req), .sched_ready(sched_ready),
    .grant_valid(grant_valid), .grant_queue(grant_queue), .port_status(port_status));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // tx verdict stands one cycle after the request, so look there
  task automatic tx(input logic [13:0] n, input logic p);
    @(posedge clock);
    tx_valid <= 1'b1;
    tx_len   <= n;
    @(posedge clock);
    tx_valid <= 1'b0;
    #1 check("tx", {tx_done, tx_pass}, {1'b1, p});
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rx(input rx_frame_type f, output rx_verdict_type v);
    @(posedge clock);
    send     <= 1'b1;
    frame_in <= f;
    @(posedge clock);
    send <= 1'b0;
    @(posedge clock);
    #1 v = rx_verdict;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    rx_verdict_type v;
    rx_frame_type f;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(OFF_CTRL, d);      check("ctrl", d, 32'h0);
    rd(OFF_INTERVAL, d);  check("interval", d, 32'h5);
    rd(OFF_STATUS, d);    check("status", d, 32'h4);
    rd(8'hfc, d);         check("unmapped", d, 32'h0);
    // boundary writes are clamped into the legal ranges
    wr(OFF_INTERVAL, 32'h28);  rd(OFF_INTERVAL, d);  check("iv max", d, 32'h1e);
    wr(OFF_DROP_N, 32'h0);     rd(OFF_DROP_N, d);    check("n min", d, 32'h1);
    wr(OFF_DROP_N, 32'h4000);  rd(OFF_DROP_N, d);    check("n max", d, 32'h3e80);
    wr(OFF_COUNTDOWN, 32'h3);  rd(OFF_COUNTDOWN, d); check("cd", d, 32'h5);
    wr(OFF_COUNTDOWN, 32'h0);  rd(OFF_COUNTDOWN, d); check("cd 0", d, 32'h0);
    wr(OFF_SHUT_TH, 32'hfffff); rd(OFF_SHUT_TH, d);  check("shut", d, 32'h3e418);
    wr(OFF_BW_RATE, 32'h1);    rd(OFF_BW_RATE, d);   check("rate", d, 32'h3f);
    // random frames in forward then filter mode
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      f = '0;
      f.mcast = seed[0];
      f.registered = seed[1];
      f.bpdu = seed[2];
      f.len = 14'h0040 + seed[9:3];
      if (i == 20) wr(OFF_CTRL, 32'h20);
      rx(f, v);
      check("done", v.done, 1'b1);
      check("cpu", v.to_cpu, f.bpdu);
      if (i < 20) check("fwd", v.pass, 1'b1);
      else check("flt", v.pass, !(f.mcast && !f.registered));
    end
    // tx ceiling: off, then on for a frame above the bucket, then lifted
    tx(14'h0040, 1'b1);
    wr(OFF_CTRL, 32'h200);
    tx(14'h0800, 1'b0);
    wr(OFF_CTRL, 32'h280);
    tx(14'h0800, 1'b1);
    // drop action on broadcast: a full bucket passes one frame, then drops
    f = '0;
    f.bcast = 1'b1;
    f.len = 14'h05dc;
    wr(OFF_DROP_N, 32'h1);
    wr(OFF_CTRL, 32'h5);
    rx(f, v);
    check("storm 1st", v.pass, 1'b1);
    rx(f, v);
    check("storm drop", v.pass, 1'b0);
    check("storm flag", port_status.storm, 1'b1);
    wr(OFF_CTRL, 32'h45);
    rx(f, v);
    check("lag pass", v.pass, 1'b1);
    check("lag status", port_status, 3'b100);
    // strict mode: the top queue wins while it requests
    wr(OFF_CTRL, 32'h800);
    queue_req   <= 8'hff;
    sched_ready <= 1'b1;
    #1;
    for (int i = 0; i < 20 && grant_valid !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check("strict", {grant_valid, grant_queue}, 4'hf);
    // round robin must reach a lone low queue
    @(posedge clock);
    queue_req <= 8'h01;
    wr(OFF_CTRL, 32'h0);
    #1;
    for (int i = 0; i < 20 && !(grant_valid === 1'b1 && grant_queue === 3'h0); i++) begin
      @(posedge clock);
      #1;
    end
    check("wrr", {grant_valid, grant_queue}, 4'h8);
    complete_run();
  end

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule

`default_nettype wire
